// ===== hw/sarp_pkg.sv
// Shared constants and carrier types for the converter read port.
// Assumes a single 40 MHz clock; all times are turned into cycle counts here.
package sarp_pkg;
  localparam int unsigned CLK_MHZ = 40;
  // Abort window after a conversion start edge, in ns.
  localparam int unsigned ABORT_MIN_NS = 70;
  localparam int unsigned ABORT_MAX_NS = 500;
  // Conversion time, in ns; the busy pulse may last at most this long.
  localparam int unsigned CONV_NS = 610;
  // End of conversion to valid data, in ns.
  localparam int unsigned DATA_DELAY_NS = 20;
  // Least times round up, longest times round down, the data delay never below one cycle.
  localparam int unsigned ABORT_MIN_CYC = (ABORT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ABORT_MAX_CYC = (ABORT_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam int unsigned DATA_DELAY_RAW = (DATA_DELAY_NS * CLK_MHZ) / 1000;
  localparam int unsigned DATA_DELAY_CYC = (DATA_DELAY_RAW < 1) ? 1 : DATA_DELAY_RAW;
  localparam int unsigned CNT_W = 10;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] FOLD_FILL = 8'hff;

  // Host-side control pins after synchronisation.
  typedef struct packed {
    logic chip_select_n;
    logic conversion_start_n;
    logic read_n;
    logic byte_fold;
  } sarp_ctl_t;

  // Idle pin levels held in the synchronisers during reset. Fold idles low so
  // the data pins come out of reset unfolded, showing the reset result.
  localparam sarp_ctl_t CTL_IDLE = '{
    chip_select_n: 1'b1,
    conversion_start_n: 1'b1,
    read_n: 1'b1,
    byte_fold: 1'b0
  };

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQUIRE,
    ST_CONVERT
  } sarp_state_t;
endpackage

// ===== hw/sarp_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides share clk; a stalled drain fills it and drops in_ready.
`timescale 1ns/1ps
`default_nettype none
module sarp_skid
  import sarp_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  // Handshake terms are combinational; full and empty come from the count.
  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // Storage writes.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ===== hw/sarp_read_port.sv
// Digital control and parallel read-out port of a 16-bit sampling converter.
// Assumes host pins are asynchronous to clk; the analog core hands over a
// result word through conv_data/conv_valid with conv_ready as back-pressure.
`timescale 1ns/1ps
`default_nettype none
module sarp_read_port
  import sarp_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Host control pins, asynchronous.
  input wire logic chip_select_n,
  input wire logic conversion_start_n,
  input wire logic read_n,
  input wire logic byte_fold,
  // Status pin.
  output logic busy,
  // Data pins as output and enable.
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Converter core: start pulse, abort pulse and result word.
  output logic conv_start,
  output logic conv_abort,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire logic [DATA_W-1:0] conv_data
);
  // Synchroniser stages and edge history, one field per host pin.
  sarp_ctl_t meta_reg;
  sarp_ctl_t sync_reg;
  sarp_ctl_t prev_reg;
  sarp_state_t state_reg;
  logic [CNT_W-1:0] since_start_reg;
  logic [CNT_W-1:0] conv_cnt_reg;
  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] result_next;
  logic [DATA_W-1:0] data_reg;
  logic oe_reg;
  logic start_pulse_reg;
  logic abort_pulse_reg;
  // Decoded events and handshake terms.
  logic cs_fall;
  logic cst_fall;
  logic in_window;
  logic abort_hit;
  logic done;
  logic buf_valid;
  logic buf_ready;
  logic [DATA_W-1:0] buf_data;

  // Two flip-flops on every host pin; only the second stage is read.
  // The third stage is edge history only; it feeds nothing but the
  // falling-edge detectors below.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= CTL_IDLE;
      sync_reg <= CTL_IDLE;
      prev_reg <= CTL_IDLE;
    end else begin
      meta_reg <= '{chip_select_n, conversion_start_n, read_n, byte_fold};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Falling edges: one cycle older level high, current level low. Both stages
  // reset to the idle levels, so no false edge follows reset.
  assign cs_fall = prev_reg.chip_select_n && !sync_reg.chip_select_n;
  assign cst_fall = prev_reg.conversion_start_n && !sync_reg.conversion_start_n;

  // The edge counter reads k at the edge k cycles after the start edge, so
  // the window bounds compare directly. Both pins see the same synchroniser
  // lag, which cancels out of the distance between the two edges.
  // A second start edge only aborts while chip select is low.
  assign in_window = (since_start_reg >= CNT_W'(ABORT_MIN_CYC)) &&
                     (since_start_reg <= CNT_W'(ABORT_MAX_CYC));
  assign abort_hit = (state_reg == ST_CONVERT) && in_window &&
                     (cs_fall || (cst_fall && !sync_reg.chip_select_n));

  // The last convert cycle; the result hand-off and the busy fall share it.
  assign done = (state_reg == ST_CONVERT) && (conv_cnt_reg == CNT_W'(0));

  // Acquire, convert and abort sequencing.
  // A start edge straight from idle converts without a new acquisition unless a select fall in the same cycle sends it to acquire; the
  // host owns the sampling time, so the port does not police it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cs_fall) begin
            state_reg <= ST_ACQUIRE;
          end else if (cst_fall) begin
            state_reg <= ST_CONVERT;
          end
        end
        ST_ACQUIRE: begin
          if (cst_fall) begin
            state_reg <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (abort_hit) begin
            state_reg <= cs_fall ? ST_ACQUIRE : ST_IDLE;
          end else if (done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Cycles since the start edge, and cycles left in the conversion.
  // The edge counter saturates, so a long stay in convert never wraps back
  // into the abort window.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_start_reg <= '0;
      conv_cnt_reg <= '0;
    end else if (state_reg != ST_CONVERT && cst_fall) begin
      // Loaded with one, as the next edge is already one cycle after the start.
      since_start_reg <= CNT_W'(1);
      conv_cnt_reg <= CNT_W'(CONV_CYC - 1);
    end else if (state_reg == ST_CONVERT) begin
      if (since_start_reg != '1) begin
        since_start_reg <= since_start_reg + CNT_W'(1);
      end
      if (conv_cnt_reg != '0) begin
        conv_cnt_reg <= conv_cnt_reg - CNT_W'(1);
      end
    end
  end

  // Busy mirrors the convert state exactly; it decodes one state register
  // only, so it cannot glitch between conversions.
  assign busy = (state_reg == ST_CONVERT);

  // One-cycle pulses toward the core.
  // The start pulse rises together with busy, or alone when a select fall in idle takes a start edge to acquire; the abort pulse follows the
  // edge at which an abort ended the conversion.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_pulse_reg <= 1'b0;
      abort_pulse_reg <= 1'b0;
    end else begin
      start_pulse_reg <= (state_reg != ST_CONVERT) && cst_fall;
      abort_pulse_reg <= abort_hit;
    end
  end
  assign conv_start = start_pulse_reg;
  assign conv_abort = abort_pulse_reg;

  // Results pass a two-entry buffer so a core word is kept if the port stalls.
  sarp_skid #(
    .WIDTH(DATA_W)
  ) u_skid (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data(conv_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // The result register only changes outside a conversion or at its last
  // cycle, so the previous word stays readable until the running conversion
  // has ended. A word the core offers early waits in the buffer meanwhile.
  assign buf_ready = (state_reg != ST_CONVERT) || done;

  // Value the result register takes at this edge. The pin stage reads it, so
  // a new word reaches the pins at the very edge where busy falls, well
  // inside the data delay allowed after the end of conversion.
  assign result_next = (buf_valid && buf_ready) ? buf_data : result_reg;

  // Last word handed over; a burst of words leaves the newest one here.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_reg <= RESULT_RST;
    end else begin
      result_reg <= result_next;
    end
  end

  // Fold mux and drive enable; one registered stage keeps the pins glitch free.
  // Fold and read pass the synchronisers first, so the pins follow a change of
  // either pin three edges later; the host must allow for that.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_reg <= RESULT_RST;
      oe_reg <= 1'b0;
    end else begin
      if (sync_reg.byte_fold) begin
        data_reg <= {result_next[7:0], FOLD_FILL};
      end else begin
        data_reg <= result_next;
      end
      oe_reg <= !sync_reg.read_n && !sync_reg.chip_select_n;
    end
  end
  // Pins are driven straight from flip-flops.
  assign data_out = data_reg;
  assign data_oe = oe_reg;
endmodule
`default_nettype wire

// ===== verification/sarp_core_model.sv
// Model of the converter core: answers each start pulse with result words.
// Assumes the bench sets burst before the pulse that it applies to.
`timescale 1ns/1ps
`default_nettype none
module sarp_core_model
  import sarp_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Core side of the port.
  input wire logic conv_start,
  output logic conv_valid,
  input wire logic conv_ready,
  output logic [15:0] conv_data,
  // Words per start, and words taken so far.
  input wire logic [1:0] burst,
  output var int sent
);
  // A word is held until taken; a released bus shows inverted noise.
  initial begin
    conv_valid = 1'b0;
    conv_data = 16'h0000;
    sent = 0;
    forever begin
      @(posedge clk);
      if (conv_start) begin
        repeat (12) @(posedge clk);
        for (int i = 0; i < burst; i++) begin
          conv_valid <= 1'b1;
          conv_data <= 16'hc3a5 + 16'(sent);
          do @(posedge clk); while (!conv_ready);
          sent++;
        end
        conv_valid <= 1'b0;
        conv_data <= ~conv_data;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/sarp_read_port_asserts.sv
// Checker for the read port pins and core handshake.
// Assumes the bind below attaches it to every port instance.
`timescale 1ns/1ps
`default_nettype none
module sarp_read_port_asserts
  import sarp_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Observed pins.
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic byte_fold,
  input wire logic busy,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_ready
);
  localparam int CONV_C = CONV_CYC;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Pins pass synchronisers, so each relation allows for that lag.
  busy_span_a: assert property ($rose(busy) |-> busy[*3] ##[1:CONV_C] !busy)
    else $error("busy length wrong");
  start_pulse_a: assert property ($rose(busy) |-> conv_start ##1 !conv_start)
    else $error("no start pulse");
  fold_fill_a: assert property (byte_fold[*6] |-> data_out[7:0] == FOLD_FILL)
    else $error("fold fill wrong");
  read_float_a: assert property (read_n[*5] |-> !data_oe)
    else $error("bus driven with read high");
  cs_float_a: assert property (chip_select_n[*5] |-> !data_oe)
    else $error("bus driven with select high");
  read_drive_a: assert property ((!read_n && !chip_select_n)[*5] |-> data_oe)
    else $error("bus not driven in read");
  hold_prev_a: assert property ($stable(byte_fold)[*5] ##0 (busy && $past(busy))
    |-> $stable(data_out)) else $error("result changed during conversion");
  abort_stop_a: assert property (conv_abort |-> ##[0:1] !busy)
    else $error("abort did not stop busy");
  cover property (conv_abort);
  cover property (!conv_ready);
  cover property (data_oe && byte_fold);
endmodule
bind sarp_read_port sarp_read_port_asserts #(.DATA_W(DATA_W)) sarp_read_port_asserts_i (
  .clk(clk), .rst_n(rst_n), .chip_select_n(chip_select_n), .read_n(read_n),
  .byte_fold(byte_fold), .busy(busy), .data_out(data_out), .data_oe(data_oe),
  .conv_start(conv_start), .conv_abort(conv_abort), .conv_ready(conv_ready));
`default_nettype wire

// ===== verification/test_sar_adc_parallel_read_port.sv
// Bench: drives the host pins of the read port with a core model behind it.
// Assumes the package constants; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_parallel_read_port
  import sarp_pkg::*;
;
  logic clk, rst_n, chip_select_n, conversion_start_n, read_n, byte_fold, hit;
  logic busy, data_oe, conv_start, conv_abort, conv_valid, conv_ready;
  logic [15:0] data_out, conv_data, mid, w;
  logic [1:0] burst;
  int sent;
  int len, num_errors = 0, comparisons = 0;
  sarp_read_port sarp_read_port_i (.clk(clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
    .conversion_start_n(conversion_start_n), .read_n(read_n), .byte_fold(byte_fold),
    .busy(busy), .data_out(data_out), .data_oe(data_oe), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_data(conv_data));
  sarp_core_model sarp_core_model_i (.clk(clk), .conv_start(conv_start), .burst(burst),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_data(conv_data), .sent(sent));
  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Count a comparison and report a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Select, pulse start, count busy; a re-start at cycle ab, hit marks refusal or abort.
  task automatic convert(input logic [1:0] n, input int ab);
    burst = n;
    hit = 1'b0;
    @(negedge clk) chip_select_n = 1'b0;
    @(negedge clk) conversion_start_n = 1'b0;
    @(negedge clk) conversion_start_n = 1'b1;
    for (int k = 0; k < 8 && !busy; k++) @(negedge clk);
    for (len = 0; len < 40 && busy; len++) begin
      if (len == 10) mid = data_out;
      conversion_start_n = (len != ab);
      hit |= conv_abort || !conv_ready;
      @(negedge clk);
    end
    repeat (4) begin
      hit |= conv_abort;
      @(negedge clk);
    end
  endtask
  // Fold is settled before the read edge, since it steers the pins.
  task automatic read_word(input logic fold, input logic [15:0] exp);
    @(negedge clk) byte_fold = fold;
    @(negedge clk) read_n = 1'b0;
    repeat (5) @(negedge clk);
    check(data_out, exp);
    check({15'h0000, data_oe}, 16'h0001);
    read_n = 1'b1;
    repeat (5) @(negedge clk);
    check({15'h0000, data_oe}, 16'h0000);
  endtask
  // Conversion, then the word read whole and as a folded half.
  task automatic test_convert_read();
    w = 16'hc3a5 + 16'(sent);
    convert(2'd1, 99);
    check(16'(len), 16'(CONV_CYC));
    check(data_out, w);
    read_word(1'b0, w);
    read_word(1'b1, {w[7:0], FOLD_FILL});
    byte_fold = 1'b0;
  endtask
  // Read held over a conversion whose three words overfill the buffer.
  task automatic test_zero_latency();
    read_n = 1'b0;
    convert(2'd3, 99);
    read_n = 1'b1;
    check(mid, w);
    check({15'h0000, hit}, 16'h0001);
    check(16'(sent), 16'h0004);
    check(data_out, w + 16'd3);
  endtask
  // A second start edge in the window aborts; a select rise floats the bus.
  task automatic test_abort();
    convert(2'd0, 5);
    check({15'h0000, hit}, 16'h0001);
    check({15'h0000, len < 20}, 16'h0001);
    read_n = 1'b0;
    repeat (5) @(negedge clk);
    chip_select_n = 1'b1;
    repeat (5) @(negedge clk);
    check({15'h0000, data_oe}, 16'h0000);
    read_n = 1'b1;
  endtask
  // Restarts at the last cycle inside the window and the first one after it;
  // a restart at loop step k lands k plus three cycles after the start edge.
  task automatic test_window_edges();
    convert(2'd0, ABORT_MAX_CYC - 3);
    check({15'h0000, hit}, 16'h0001);
    check(16'(len), 16'(ABORT_MAX_CYC));
    convert(2'd0, ABORT_MAX_CYC - 2);
    check({15'h0000, hit}, 16'h0000);
    check(16'(len), 16'(CONV_CYC));
  endtask
  // A select fall four cycles after the start edge aborts the conversion.
  task automatic test_cs_abort();
    burst = 2'd0;
    hit = 1'b0;
    @(negedge clk) conversion_start_n = 1'b0;
    @(negedge clk) conversion_start_n = 1'b1;
    chip_select_n = 1'b1;
    repeat (3) @(negedge clk);
    chip_select_n = 1'b0;
    repeat (6) begin
      hit |= conv_abort;
      @(negedge clk);
    end
    check({15'h0000, hit}, 16'h0001);
    check({15'h0000, busy}, 16'h0000);
  endtask
  // Reset for five cycles, then each scenario in turn.
  initial begin
    rst_n = 1'b0;
    {chip_select_n, conversion_start_n, read_n, byte_fold, burst} = 6'h38;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    test_convert_read();
    test_zero_latency();
    test_abort();
    test_window_edges();
    test_cs_abort();
    final_report();
  end
  // Watchdog: the scenarios take about two hundred cycles.
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
